//--- common/tw_regs.svh
// Constants for the three-wire register port: command codes, field positions
// and timing. Included by both ends; holds definitions only.
`ifndef TW_REGS_SVH
`define TW_REGS_SVH

`define TW_BITS_PER_CYCLE 4'h8
`define TW_CMD_MSB 7
`define TW_CMD_LSB 6
`define TW_ADDR_MSB 5
`define TW_ADDR_LSB 0
`define TW_CMD_READ 2'h0
`define TW_CMD_NOP 2'h1
`define TW_CMD_WRITE 2'h2
`define TW_CMD_BURST 2'h3
`define TW_CLK_DIV_HALF 4'h4
`define TW_CS_GAP 4'h8

`endif

//--- common/tw_pkg.sv
// Types shared by both ends of the three-wire register port.
// Assumes the constants header is included alongside.
package tw_pkg;
  typedef enum logic [1:0] {
    TW_CMD_RD,
    TW_CMD_NO,
    TW_CMD_WR,
    TW_CMD_BW
  } tw_cmd_t;
  typedef logic [5:0] tw_addr_t;
  typedef logic [7:0] tw_byte_t;
endpackage

//--- common/tw_if.sv
// Serial link between master (host) and register port (device).
// Assumes both ends run on their own clocks; no clocking block here.
`timescale 1ns/100ps
interface tw_if;
  logic chip_sel_n;
  logic shift_clock;
  logic ser_in;
  logic ser_out;
  modport dev (input chip_sel_n, input shift_clock, input ser_in,
               output ser_out);
  modport host (output chip_sel_n, output shift_clock, output ser_in,
                input ser_out);
endinterface

//--- core/tw_device.sv
// Device end of the three-wire register port: shifts bytes in and out and
// drives a simple register-file access port on the user side.
// Assumes link pins are asynchronous to i_clock and are synchronised here.
// Assumes the register file answers a read strobe on the next cycle.
`timescale 1ns/100ps
`include "tw_regs.svh"
module tw_device
  import tw_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  tw_if.dev link,
  output logic o_rd_en,
  output logic o_rd_clr_ok,
  output logic [5:0] o_rd_addr,
  input wire logic [7:0] i_rd_data,
  output logic o_wr_en,
  output logic [5:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  output logic o_active
);
  typedef enum logic [1:0] {
    TW_ST_CMD,
    TW_ST_DATA,
    TW_ST_BURST
  } tw_state_t;

  logic [1:0] cs_sync_reg;
  logic [2:0] sk_sync_reg;
  logic [1:0] si_sync_reg;
  logic cs_n;
  logic sk_rise;
  logic sk_fall;
  logic [7:0] rx_shift_reg;
  logic [7:0] tx_shift_reg;
  logic [3:0] bit_cnt_reg;
  tw_state_t state_reg;
  logic [5:0] addr_reg;
  logic load_pend_reg;
  logic so_reg;
  logic [7:0] rx_byte;
  logic byte_done;

  // Field decoding shared by the command state and the strobe logic
  function automatic logic [1:0] cmd_of(input tw_byte_t b);
    return b[`TW_CMD_MSB:`TW_CMD_LSB];
  endfunction

  function automatic tw_addr_t addr_of(input tw_byte_t b);
    return b[`TW_ADDR_MSB:`TW_ADDR_LSB];
  endfunction

  // Two flops before use; the third shift-clock stage only feeds edge
  // detection, so nothing but the second flop ever reads the first
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      cs_sync_reg <= 2'h3;
      sk_sync_reg <= 3'h0;
      si_sync_reg <= 2'h0;
    end else if (i_clk_en) begin
      cs_sync_reg <= {cs_sync_reg[0], link.chip_sel_n};
      sk_sync_reg <= {sk_sync_reg[1:0], link.shift_clock};
      si_sync_reg <= {si_sync_reg[0], link.ser_in};
    end
  end

  // Edge strobes and the byte that the current rise would complete.
  // Shift clock and data share one latency, so the bit taken is the one
  // that stood on the pin at the rise.
  assign cs_n = cs_sync_reg[1];
  assign sk_rise = sk_sync_reg[1] & ~sk_sync_reg[2];
  assign sk_fall = ~sk_sync_reg[1] & sk_sync_reg[2];
  assign rx_byte = {rx_shift_reg[6:0], si_sync_reg[1]};
  // Eighth synchronised rise while selected closes a byte
  assign byte_done = !cs_n && sk_rise &&
                     bit_cnt_reg == `TW_BITS_PER_CYCLE - 4'h1;

  // Receive shift and bit count; deselect clears the count so a cut
  // byte never leaks into the next frame
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      rx_shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
    end else if (i_clk_en) begin
      if (cs_n) begin
        bit_cnt_reg <= 4'h0;
      end else if (sk_rise) begin
        rx_shift_reg <= rx_byte;
        bit_cnt_reg <= byte_done ? 4'h0 : bit_cnt_reg + 4'h1;
      end
    end
  end

  // Command state; deselect ends any burst
  // A burst has no length field, so only select high can stop it
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state_reg <= TW_ST_CMD;
      addr_reg <= 6'h00;
    end else if (i_clk_en) begin
      if (cs_n) begin
        state_reg <= TW_ST_CMD;
      end else if (byte_done) begin
        case (state_reg)
          TW_ST_CMD: begin
            addr_reg <= addr_of(rx_byte);
            case (cmd_of(rx_byte))
              `TW_CMD_WRITE: state_reg <= TW_ST_DATA;
              `TW_CMD_BURST: state_reg <= TW_ST_BURST;
              // Read and no-op need no data byte
              default: state_reg <= TW_ST_CMD;
            endcase
          end
          // One data byte, then commands again
          TW_ST_DATA: state_reg <= TW_ST_CMD;
          TW_ST_BURST: state_reg <= TW_ST_BURST;
          default: state_reg <= TW_ST_CMD;
        endcase
      end
    end
  end

  // Register-file strobes issued only on a complete byte.
  // Only the read command may clear flags; every other read strobe here
  // fetches output data and must leave clear-on-read bits alone
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_rd_en <= 1'b0;
      o_rd_clr_ok <= 1'b0;
      o_rd_addr <= 6'h00;
      o_wr_en <= 1'b0;
      o_wr_addr <= 6'h00;
      o_wr_data <= 8'h00;
      load_pend_reg <= 1'b0;
    end else if (i_clk_en) begin
      o_rd_en <= 1'b0;
      o_wr_en <= 1'b0;
      o_rd_clr_ok <= 1'b0;
      load_pend_reg <= o_rd_en;
      if (byte_done && state_reg == TW_ST_CMD) begin
        case (cmd_of(rx_byte))
          `TW_CMD_READ: begin
            o_rd_en <= 1'b1;
            o_rd_clr_ok <= 1'b1;
            o_rd_addr <= addr_of(rx_byte);
          end
          // No access at all, so nothing can be cleared
          `TW_CMD_NOP: o_rd_en <= 1'b0;
          default: begin
            // Show the target before data arrives, no flag clearing
            o_rd_en <= 1'b1;
            o_rd_addr <= addr_of(rx_byte);
          end
        endcase
      end else if (byte_done) begin
        // Data byte: write, then fetch the same place for the next cycle
        o_wr_en <= 1'b1;
        o_wr_addr <= addr_reg;
        o_wr_data <= rx_byte;
        o_rd_en <= 1'b1;
        o_rd_addr <= addr_reg;
      end
    end
  end

  // Transmit shift: loaded after the eighth clock, advanced on falls.
  // The load waits one cycle for i_rd_data; the fall that closes a byte
  // sees a zero count and is skipped, so the fresh bit 7 is not lost
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      tx_shift_reg <= 8'h00;
      so_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (load_pend_reg) begin
        tx_shift_reg <= i_rd_data;
        so_reg <= i_rd_data[7];
      end else if (!cs_n && sk_fall && bit_cnt_reg != 4'h0) begin
        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
        so_reg <= tx_shift_reg[6];
      end
    end
  end

  // Busy flag for the user side
  // Lags the pin by the synchroniser and this flop
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_active <= 1'b0;
    end else if (i_clk_en) begin
      o_active <= !cs_n;
    end
  end

  // Serial output comes straight from its flop
  assign link.ser_out = so_reg;
endmodule

//--- core/tw_host.sv
// Master end of the three-wire register port: sends a command byte and,
// for writes, data bytes; returns each byte shifted back.
// Assumes ser_out from the device is asynchronous to i_clock.
`timescale 1ns/100ps
`include "tw_regs.svh"
module tw_host
  import tw_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  tw_if.host link,
  input wire logic i_start,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire logic i_last,
  output logic o_byte_req,
  output logic [7:0] o_rx_byte,
  output logic o_rx_valid,
  output logic o_busy
);
  typedef enum logic [1:0] {
    TW_H_IDLE,
    TW_H_SHIFT,
    TW_H_WAIT,
    TW_H_GAP
  } tw_hstate_t;

  tw_hstate_t st_reg;
  logic [1:0] so_sync_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic [3:0] div_reg;
  logic [3:0] bit_reg;
  logic sk_reg;
  logic cs_reg;
  logic last_reg;

  // Input from device clock domain passes two flops
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      so_sync_reg <= 2'h0;
    end else if (i_clk_en) begin
      so_sync_reg <= {so_sync_reg[0], link.ser_out};
    end
  end

  // Byte engine; shift clock made by dividing i_clock
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      st_reg <= TW_H_IDLE;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      div_reg <= 4'h0;
      bit_reg <= 4'h0;
      sk_reg <= 1'b0;
      cs_reg <= 1'b1;
      last_reg <= 1'b0;
      o_byte_req <= 1'b0;
      o_rx_byte <= 8'h00;
      o_rx_valid <= 1'b0;
      o_busy <= 1'b0;
    end else if (i_clk_en) begin
      o_byte_req <= 1'b0;
      o_rx_valid <= 1'b0;
      case (st_reg)
        TW_H_IDLE: begin
          if (i_start && i_byte_valid) begin
            cs_reg <= 1'b0;
            tx_reg <= i_byte;
            last_reg <= i_last;
            bit_reg <= 4'h0;
            div_reg <= 4'h0;
            o_byte_req <= 1'b1;
            o_busy <= 1'b1;
            st_reg <= TW_H_SHIFT;
          end
        end
        TW_H_SHIFT: begin
          div_reg <= div_reg + 4'h1;
          if (div_reg == `TW_CLK_DIV_HALF - 4'h1) begin
            div_reg <= 4'h0;
            sk_reg <= ~sk_reg;
            if (sk_reg) begin
              // Falling edge: take the device bit late in the high phase;
              // both synchronisers make a grab at the rise one bit stale
              rx_reg <= {rx_reg[6:0], so_sync_reg[1]};
              tx_reg <= {tx_reg[6:0], 1'b0};
              bit_reg <= bit_reg + 4'h1;
              if (bit_reg == `TW_BITS_PER_CYCLE - 4'h1) begin
                o_rx_byte <= {rx_reg[6:0], so_sync_reg[1]};
                o_rx_valid <= 1'b1;
                st_reg <= TW_H_WAIT;
              end
            end
          end
        end
        TW_H_WAIT: begin
          // Wait for next byte or end the frame
          if (last_reg) begin
            cs_reg <= 1'b1;
            div_reg <= 4'h0;
            st_reg <= TW_H_GAP;
          end else if (i_byte_valid) begin
            tx_reg <= i_byte;
            last_reg <= i_last;
            bit_reg <= 4'h0;
            o_byte_req <= 1'b1;
            st_reg <= TW_H_SHIFT;
          end
        end
        TW_H_GAP: begin
          // Hold select high long enough for device to see it
          div_reg <= div_reg + 4'h1;
          if (div_reg == `TW_CS_GAP) begin
            o_busy <= 1'b0;
            st_reg <= TW_H_IDLE;
          end
        end
        default: st_reg <= TW_H_IDLE;
      endcase
    end
  end

  assign link.chip_sel_n = cs_reg;
  assign link.shift_clock = sk_reg;
  assign link.ser_in = tx_reg[7];
endmodule

//--- sim/tw_link_properties.sv
// Link-level properties between the host and device ends of the port.
// Assumes both ends share i_clock; link pins are watched unsynchronised.
`timescale 1ns/100ps
module tw_link_properties (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic chip_sel_n,
  input wire logic shift_clock,
  input wire logic ser_in,
  input wire logic ser_out
);
  logic sck_q_reg;
  logic [2:0] rise_cnt_reg;

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  // Previous shift clock level, for edge detection
  always_ff @(posedge i_clock) begin
    sck_q_reg <= shift_clock;
  end

  // Rises within the frame; wraps every byte so a whole frame ends at zero
  always_ff @(posedge i_clock) begin
    if (!i_reset_n || chip_sel_n) begin
      rise_cnt_reg <= 3'h0;
    end else if (shift_clock && !sck_q_reg) begin
      rise_cnt_reg <= rise_cnt_reg + 3'h1;
    end
  end

  sequence s_high_phase;
    shift_clock [*4] ##1 !shift_clock;
  endsequence
  sequence s_low_phase;
    (!shift_clock) [*4] ##1 shift_clock;
  endsequence

  property p_half_period;
    $rose(shift_clock) |-> s_high_phase;
  endproperty
  a_half_period: assert property (p_half_period)
    else $error("shift clock high phase is not four cycles");

  property p_low_in_byte;
    $fell(shift_clock) && rise_cnt_reg != 3'h0 |-> s_low_phase;
  endproperty
  a_low_in_byte: assert property (p_low_in_byte)
    else $error("shift clock low phase inside a byte is not four cycles");

  property p_frame_bits;
    $rose(chip_sel_n) |-> rise_cnt_reg == 3'h0;
  endproperty
  a_frame_bits: assert property (p_frame_bits)
    else $error("frame ended on a partial byte");

  property p_rise_gap;
    $rose(shift_clock) |=> (!$rose(shift_clock)) [*7];
  endproperty
  a_rise_gap: assert property (p_rise_gap)
    else $error("shift clock rises closer than eight cycles");

  property p_idle_clock;
    chip_sel_n |-> !shift_clock;
  endproperty
  a_idle_clock: assert property (p_idle_clock)
    else $error("shift clock high while deselected");

  property p_in_steady;
    shift_clock && $past(shift_clock) |-> $stable(ser_in);
  endproperty
  a_in_steady: assert property (p_in_steady)
    else $error("serial input moved in the high phase");

  property p_out_steady;
    shift_clock && $past(shift_clock) |-> $stable(ser_out);
  endproperty
  a_out_steady: assert property (p_out_steady)
    else $error("serial output moved in the high phase");

  property p_cs_gap;
    $rose(chip_sel_n) |-> chip_sel_n [*8];
  endproperty
  a_cs_gap: assert property (p_cs_gap)
    else $error("select high for fewer than eight cycles");
endmodule

//--- sim/three_wire_register_port_tb.sv
// Bench: host and device face each other over one link; a bare device
// on a spare link takes deliberate faults. The register file is modelled here.
`timescale 1ns/100ps
`include "tw_regs.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t %h %h", $time, (a), (b)); end end
module three_wire_register_port_tb;
  import tw_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic start = 1'b0;
  logic bvalid = 1'b0;
  logic last = 1'b0;
  tw_byte_t byte_in = 8'h00;
  tw_byte_t rd_data = 8'h00;
  tw_byte_t mem [64];
  tw_byte_t rxq [$];
  int error_cnt = 0, checks = 0, cyc = 0;
  int wr_cnt = 0, clr_cnt = 0, b_wr_cnt = 0;
  logic rd_en, clr_ok, wr_en, byte_req, rx_valid, busy, b_wr_en;
  logic active, b_active;
  logic b_clk_en = 1'b1;
  logic [5:0] rd_addr, wr_addr;
  tw_byte_t wr_data, rx_byte, b_wr_data, b_wdata;

  tw_if u_tw_if();
  tw_if u_tw_if_b();
  tw_host u_tw_host (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_clk_en(1'b1), .link(u_tw_if), .i_start(start), .i_byte_valid(bvalid),
    .i_byte(byte_in), .i_last(last), .o_byte_req(byte_req),
    .o_rx_byte(rx_byte), .o_rx_valid(rx_valid), .o_busy(busy));
  tw_device u_tw_device (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_clk_en(1'b1), .link(u_tw_if), .o_rd_en(rd_en), .o_rd_clr_ok(clr_ok),
    .o_rd_addr(rd_addr), .i_rd_data(rd_data), .o_wr_en(wr_en),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_active(active));
  tw_device u_tw_device_b (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_clk_en(b_clk_en), .link(u_tw_if_b), .o_rd_en(), .o_rd_clr_ok(),
    .o_rd_addr(), .i_rd_data(8'h00), .o_wr_en(b_wr_en), .o_wr_addr(),
    .o_wr_data(b_wr_data), .o_active(b_active));
  tw_link_properties u_tw_link_properties (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .chip_sel_n(u_tw_if.chip_sel_n),
    .shift_clock(u_tw_if.shift_clock), .ser_in(u_tw_if.ser_in),
    .ser_out(u_tw_if.ser_out));

  initial begin
    forever #20 i_clock = ~i_clock;
  end

  function automatic tw_byte_t cb(input logic [1:0] c, input tw_addr_t a);
    return {c, a};
  endfunction
  function automatic tw_byte_t init_val(input tw_addr_t a);
    return 8'h5A ^ {2'h0, a};
  endfunction

  task automatic complete_run();
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Register file and event counts; forwarding covers a same-cycle readback
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (rd_en) begin
      rd_data <= (wr_en && wr_addr == rd_addr) ? wr_data : mem[rd_addr];
    end
    if (wr_en) mem[wr_addr] <= wr_data;
    wr_cnt <= wr_cnt + int'(wr_en);
    clr_cnt <= clr_cnt + int'(rd_en & clr_ok);
    if (b_wr_en) b_wr_cnt <= b_wr_cnt + 1;
    if (b_wr_en) b_wdata <= b_wr_data;
    if (rx_valid) rxq.push_back(rx_byte);
    if (cyc == 10000) begin
      error_cnt++;
      complete_run();
    end
  end

  // One frame through the host; the cycle ceiling guards every wait
  task automatic xfer(input tw_byte_t b[$]);
    rxq = {};
    foreach (b[i]) begin
      start <= (i == 0);
      bvalid <= 1'b1;
      byte_in <= b[i];
      last <= (i == b.size() - 1);
      do @(posedge i_clock); while (byte_req !== 1'b1);
    end
    start <= 1'b0;
    bvalid <= 1'b0;
    do @(posedge i_clock); while (busy !== 1'b0);
  endtask

  // Shift n bits of v on the spare link, four clocks per half period
  task automatic b_shift(input tw_byte_t v, input int n);
    for (int i = 0; i < n; i++) begin
      u_tw_if_b.ser_in <= v[7 - i];
      repeat (4) @(posedge i_clock);
      u_tw_if_b.shift_clock <= 1'b1;
      repeat (4) @(posedge i_clock);
      u_tw_if_b.shift_clock <= 1'b0;
    end
  endtask

  initial begin
    foreach (mem[i]) mem[i] = init_val(i[5:0]);
    u_tw_if_b.chip_sel_n <= 1'b1;
    u_tw_if_b.shift_clock <= 1'b0;
    u_tw_if_b.ser_in <= 1'b0;
    repeat (12) @(posedge i_clock);
    i_reset_n <= 1'b1;
    @(posedge i_clock);
    // Reads at both address extremes, then a no-op
    xfer({cb(`TW_CMD_READ, 6'h00), cb(`TW_CMD_READ, 6'h3F),
          cb(`TW_CMD_NOP, 6'h15)});
    `CHK(rxq.size(), 3)
    `CHK(rxq[1], init_val(6'h00))
    `CHK(rxq[2], init_val(6'h3F))
    `CHK(clr_cnt, 2)
    `CHK(active, 1'b0)
    // Plain write, then read back the same place
    xfer({cb(`TW_CMD_WRITE, 6'h2A), 8'hC3, cb(`TW_CMD_READ, 6'h2A),
          cb(`TW_CMD_NOP, 6'h00)});
    `CHK(rxq[1], init_val(6'h2A))
    `CHK(rxq[2], 8'hC3)
    `CHK(rxq[3], 8'hC3)
    `CHK(wr_cnt, 1)
    `CHK(clr_cnt, 3)
    // Burst of three data bytes to one address
    xfer({cb(`TW_CMD_BURST, 6'h07), 8'h11, 8'h22, 8'hF0});
    `CHK(rxq[1], init_val(6'h07))
    `CHK(rxq[3], 8'h22)
    `CHK(wr_cnt, 4)
    // Deselect ended the burst: this byte is a command again
    xfer({cb(`TW_CMD_READ, 6'h07), cb(`TW_CMD_NOP, 6'h00)});
    `CHK(rxq[1], 8'hF0)
    `CHK(wr_cnt, 4)
    `CHK(clr_cnt, 4)
    // Spare link: data byte cut short after three bits
    u_tw_if_b.chip_sel_n <= 1'b0;
    repeat (4) @(posedge i_clock);
    `CHK(b_active, 1'b1)
    b_shift(cb(`TW_CMD_WRITE, 6'h01), 8);
    b_shift(8'hFF, 3);
    repeat (4) @(posedge i_clock);
    u_tw_if_b.chip_sel_n <= 1'b1;
    u_tw_if_b.ser_in <= 1'b0;
    repeat (16) @(posedge i_clock);
    `CHK(b_wr_cnt, 0)
    u_tw_if_b.chip_sel_n <= 1'b0;
    repeat (4) @(posedge i_clock);
    b_shift(cb(`TW_CMD_WRITE, 6'h01), 8);
    b_shift(8'h3C, 8);
    repeat (8) @(posedge i_clock);
    u_tw_if_b.chip_sel_n <= 1'b1;
    u_tw_if_b.ser_in <= 1'b1;
    repeat (16) @(posedge i_clock);
    `CHK(b_wr_cnt, 1)
    `CHK(b_wdata, 8'h3C)
    `CHK(b_active, 1'b0)
    // Clock enable held low: a whole write frame must leave no trace
    b_clk_en <= 1'b0;
    u_tw_if_b.chip_sel_n <= 1'b0;
    repeat (4) @(posedge i_clock);
    b_shift(cb(`TW_CMD_WRITE, 6'h01), 8);
    b_shift(8'h99, 8);
    u_tw_if_b.chip_sel_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    b_clk_en <= 1'b1;
    repeat (16) @(posedge i_clock);
    `CHK(b_wr_cnt, 1)
    `CHK(b_wdata, 8'h3C)
    `CHK(b_active, 1'b0)
    complete_run();
  end
endmodule
